/* port_c_pin_mux.sv */
// Behaviour
// [RULE_01] Eight pins, each direction, latch, input
// [RULE_02] Direction one tri-states the pin driver
// [RULE_03] Direction zero drives latch unless overridden
// [RULE_04] Latch register reads stored latch values
// [RULE_05] Reset sets every direction bit to input
// [RULE_06] Peripherals may force direction either way
// [RULE_07] Direction reads return stored bits always
// [RULE_08] Pin select bit puts channel two on pin 1
// [RULE_09] Oscillator takes pins 0, 1 as analog
// [RULE_10] Pin 0 feeds timer counter input
// [RULE_11] Pins 2, 1 compare output or capture
// [RULE_12] PWM A overrides latch, optional shutdown tristate
// [RULE_13] Pin 3 SPI clock out or in
// [RULE_14] Pin 3 I2C clock drive and receive
// [RULE_15] Pin 4 SPI data input when direction one
// [RULE_16] Pin 4 I2C data drives despite direction
// [RULE_17] Pin 5 SPI data output override
// [RULE_18] Data register reads pins, writes latch
`include "pcpm_regs.svh"

module port_c_pin_mux #(
   parameter int PINS = 8
) (
   input wire logic clock,
   input wire logic arst_n,
   // Avalon-MM slave
   input wire logic [3:0] address,
   input wire logic read,
   input wire logic write,
   input wire logic [3:0] byteenable,
   input wire logic [31:0] writedata,
   output logic [31:0] readdata,
   output logic waitrequest,
   // Strap for channel two placement
   input wire logic channel_two_pin_select,
   // Peripheral side
   input wire pcpm_pkg::pcpm_periph_t periph,
   output pcpm_pkg::pcpm_taps_t taps,
   // Alternate channel two placement active
   output logic ch2_alt_pin,
   // Pads
   input wire logic [PINS-1:0] pad_in,
   output logic [PINS-1:0] pad_out,
   output logic [PINS-1:0] pad_oe,
   output logic [1:0] pad_analog,
   output logic [1:0] pad_smbus
);

   // Synchroniser chain for pad inputs
   logic [PINS-1:0] sync1;
   logic [PINS-1:0] sync2;
   logic [PINS-1:0] sync3;
   logic [PINS-1:0] pin_level;      // Filtered level
   logic [PINS-1:0] next_pin_level;

   // Software visible storage
   logic [PINS-1:0] output_latch;        // [RULE_01]
   logic [PINS-1:0] next_output_latch;
   logic [PINS-1:0] direction_control;
   logic [PINS-1:0] next_direction_control;

   // Captured strap
   logic pin_sel;
   logic next_pin_sel;
   logic strap_done;
   logic next_strap_done;

   // Bus handshake
   pcpm_pkg::pcpm_bus_state_t bus_state;
   pcpm_pkg::pcpm_bus_state_t next_bus_state;
   logic [31:0] next_readdata;

   // Effective pad drive
   logic [PINS-1:0] eff_oe;
   logic [PINS-1:0] eff_out;
   logic [PINS-1:0] digital_in;   // Pin levels as read
   logic [7:0] status_bits;
   pcpm_pkg::pcpm_taps_t next_taps;

   // Helper: bus write hits an offset with low lane
   function automatic logic hit(
      input logic [3:0] addr,
      input logic [3:0] ofs,
      input logic [3:0] be
   );
      hit = (addr == ofs) && be[0];
   endfunction : hit

   // Helper: zero-extend a register byte
   function automatic logic [31:0] ext(
      input logic [7:0] v
   );
      ext = {24'h000000, v};
   endfunction : ext

   // Helper: drive for a compare or PWM pin
   function automatic logic [1:0] ccp_drive(
      input logic dir,
      input logic lat,
      input logic en,
      input logic val,
      input logic shut,
      input logic shut_tri
   );
      logic oe;
      logic out;
      oe = ~dir;
      out = lat;
      if (en && !dir) begin
         out = val;                          // [RULE_11]
         if (shut && shut_tri) begin
            oe = 1'b0;                       // [RULE_12]
         end
      end
      ccp_drive = {oe, out};
   endfunction : ccp_drive

   // Next filtered level: change taken once stages agree
   always_comb begin
      next_pin_level = pin_level;
      for (int i = 0; i < PINS; i++) begin
         if (sync2[i] == sync3[i]) begin
            next_pin_level[i] = sync3[i];
         end
      end
   end

   // Three-stage input sampling
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         sync1 <= '0;
         sync2 <= '0;
         sync3 <= '0;
         pin_level <= '0;
      end else begin
         sync1 <= pad_in;
         sync2 <= sync1;
         sync3 <= sync2;
         pin_level <= next_pin_level;
      end
   end

   // Strap caught once just after reset release
   always_comb begin
      next_pin_sel = pin_sel;
      next_strap_done = 1'b1;
      if (!strap_done) begin
         next_pin_sel = channel_two_pin_select;
      end
   end

   // Strap register; reset holds the erased default
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         pin_sel <= `PCPM_RST_PIN_SEL;
         strap_done <= 1'b0;
      end else begin
         pin_sel <= next_pin_sel;
         strap_done <= next_strap_done;
      end
   end

   // Pad multiplexer, per pin priorities
   always_comb begin
      logic [1:0] d;
      d = 2'b00;
      // Plain port behaviour for every pin
      eff_oe = ~direction_control;           // [RULE_02]
      eff_out = output_latch;                // [RULE_03]
      pad_analog = 2'b00;
      pad_smbus = 2'b00;

      // Pin 2: first capture/compare channel
      d = ccp_drive(direction_control[`PCPM_PIN_CCP1],
                    output_latch[`PCPM_PIN_CCP1],
                    periph.ccp1_out_en, periph.ccp1_out,
                    periph.ccp1_shut, periph.ccp1_shut_tri);
      eff_oe[`PCPM_PIN_CCP1] = d[1];         // [RULE_06]
      eff_out[`PCPM_PIN_CCP1] = d[0];

      // Pin 1: second channel only on default placement
      if (pin_sel) begin                     // [RULE_08]
         d = ccp_drive(direction_control[`PCPM_PIN_OSC_IN],
                       output_latch[`PCPM_PIN_OSC_IN],
                       periph.ccp2_out_en, periph.ccp2_out,
                       periph.ccp2_shut, periph.ccp2_shut_tri);
         eff_oe[`PCPM_PIN_OSC_IN] = d[1];
         eff_out[`PCPM_PIN_OSC_IN] = d[0];
      end

      // Pin 3: serial clock
      if (periph.spi_en) begin
         if (!direction_control[`PCPM_PIN_CLK]) begin
            eff_out[`PCPM_PIN_CLK] = periph.spi_clk_out; // [RULE_13]
         end
      end else if (periph.i2c_en) begin
         // Open drain: only the low level is driven
         eff_out[`PCPM_PIN_CLK] = 1'b0;                  // [RULE_14]
         eff_oe[`PCPM_PIN_CLK] =
            ~direction_control[`PCPM_PIN_CLK] & periph.i2c_clk_low;
         pad_smbus[0] = periph.i2c_smbus;                // [RULE_14]
      end

      // Pin 4: serial data; I2C drives whatever the direction
      if (periph.i2c_en && !periph.spi_en) begin
         eff_out[`PCPM_PIN_DAT] = 1'b0;                  // [RULE_16]
         eff_oe[`PCPM_PIN_DAT] = periph.i2c_dat_low;     // [RULE_16]
         pad_smbus[1] = periph.i2c_smbus;
      end

      // Pin 5: SPI data out
      if (periph.spi_en && !direction_control[`PCPM_PIN_SDO]) begin
         eff_out[`PCPM_PIN_SDO] = periph.spi_sdo;        // [RULE_17]
      end

      // Oscillator wins over everything on pins 0 and 1
      if (periph.osc_en) begin
         eff_oe[1:0] = 2'b00;                            // [RULE_09]
         eff_out[1:0] = 2'b00;
         pad_analog = 2'b11;                             // [RULE_09]
      end
   end

   // Digital input path, blanked on analog pins
   always_comb begin
      digital_in = pin_level;
      if (periph.osc_en) begin
         digital_in[1:0] = 2'b00;                        // [RULE_09]
      end
   end

   // Input taps toward peripherals
   always_comb begin
      next_taps = '0;
      // Counter input only while the pin is an input
      if (direction_control[`PCPM_PIN_OSC_OUT]) begin
         next_taps.timer_counter_input =
            digital_in[`PCPM_PIN_OSC_OUT];               // [RULE_10]
      end
      if (direction_control[`PCPM_PIN_CCP1]) begin
         next_taps.ccp1_capture = digital_in[`PCPM_PIN_CCP1]; // [RULE_11]
      end
      if (pin_sel && direction_control[`PCPM_PIN_OSC_IN]) begin
         next_taps.ccp2_capture = digital_in[`PCPM_PIN_OSC_IN];
      end
      if (periph.spi_en) begin
         if (direction_control[`PCPM_PIN_CLK]) begin
            next_taps.spi_clock_pin = digital_in[`PCPM_PIN_CLK]; // [RULE_13]
         end
         if (direction_control[`PCPM_PIN_DAT]) begin
            next_taps.spi_data_in_pin =
               digital_in[`PCPM_PIN_DAT];                // [RULE_15]
         end
      end
      // Bus receivers see the wire in every direction
      if (periph.i2c_en && !periph.spi_en) begin
         next_taps.i2c_clock_pin = digital_in[`PCPM_PIN_CLK]; // [RULE_14]
         next_taps.i2c_data_pin = digital_in[`PCPM_PIN_DAT];  // [RULE_16]
      end
   end

   // Registered pad and tap outputs
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         pad_oe <= '0;
         pad_out <= '0;
         taps <= '0;
      end else begin
         pad_oe <= eff_oe;
         pad_out <= eff_out;
         taps <= next_taps;
      end
   end

   // Placement flag for the alternate pin owner
   assign ch2_alt_pin = ~pin_sel;

   // Status byte shows live multiplexer state
   always_comb begin
      status_bits = 8'h00;
      status_bits[`PCPM_ST_OSC] = periph.osc_en;
      status_bits[`PCPM_ST_CH2_PIN1] = pin_sel;
      status_bits[`PCPM_ST_SPI] = periph.spi_en;
      status_bits[`PCPM_ST_I2C] = periph.i2c_en & ~periph.spi_en;
   end

   // Bus answer: one wait cycle, then ready
   always_comb begin
      next_bus_state = bus_state;
      next_readdata = readdata;
      case (bus_state)
         pcpm_pkg::PCPM_IDLE: begin
            if (read || write) begin
               next_bus_state = pcpm_pkg::PCPM_ACK;
               next_readdata = 32'h00000000;
               // Unmapped offsets read zero
               case (address)
                  `PCPM_OFS_PINS:
                     next_readdata = ext(digital_in);    // [RULE_18]
                  `PCPM_OFS_LATCH:
                     next_readdata = ext(output_latch);  // [RULE_04]
                  `PCPM_OFS_DIR:
                     next_readdata = ext(direction_control); // [RULE_07]
                  `PCPM_OFS_STATUS:
                     next_readdata = ext(status_bits);
                  default:
                     next_readdata = 32'h00000000;
               endcase
            end
         end
         pcpm_pkg::PCPM_ACK: begin
            next_bus_state = pcpm_pkg::PCPM_IDLE;
         end
         default: begin
            next_bus_state = pcpm_pkg::PCPM_IDLE;
         end
      endcase
   end

   // Waitrequest drops in the answer cycle only
   assign waitrequest = (read | write) &
                        (bus_state != pcpm_pkg::PCPM_ACK);

   // Handshake registers
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         bus_state <= pcpm_pkg::PCPM_IDLE;
         readdata <= 32'h00000000;
      end else begin
         bus_state <= next_bus_state;
         readdata <= next_readdata;
      end
   end

   // Register writes land at the answer edge
   always_comb begin
      logic take;
      take = write && (bus_state == pcpm_pkg::PCPM_ACK);
      next_output_latch = output_latch;
      next_direction_control = direction_control;
      if (take) begin
         // Both data and latch offsets store the latch
         if (hit(address, `PCPM_OFS_PINS, byteenable) ||
             hit(address, `PCPM_OFS_LATCH, byteenable)) begin
            next_output_latch = writedata[PINS-1:0]; // [RULE_18]
         end
         // Direction stored as written, whatever overrides do
         if (hit(address, `PCPM_OFS_DIR, byteenable)) begin
            next_direction_control = writedata[PINS-1:0]; // [RULE_07]
         end
      end
   end

   // Storage; all pins come up as inputs
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         output_latch <= `PCPM_RST_LATCH;
         direction_control <= `PCPM_RST_DIR;     // [RULE_05]
      end else begin
         output_latch <= next_output_latch;
         direction_control <= next_direction_control;
      end
   end

endmodule : port_c_pin_mux

/* pcpm_regs.svh */
`ifndef PCPM_REGS_SVH
`define PCPM_REGS_SVH

// Byte offsets on the register bus
`define PCPM_OFS_PINS 4'h0
`define PCPM_OFS_LATCH 4'h4
`define PCPM_OFS_DIR 4'h8
`define PCPM_OFS_STATUS 4'hc

// Reset values
`define PCPM_RST_LATCH 8'h00
`define PCPM_RST_DIR 8'hff
`define PCPM_RST_PIN_SEL 1'b1

// Status field positions
`define PCPM_ST_OSC 0
`define PCPM_ST_CH2_PIN1 1
`define PCPM_ST_SPI 2
`define PCPM_ST_I2C 3

// Pin positions
`define PCPM_PIN_OSC_OUT 0
`define PCPM_PIN_OSC_IN 1
`define PCPM_PIN_CCP1 2
`define PCPM_PIN_CLK 3
`define PCPM_PIN_DAT 4
`define PCPM_PIN_SDO 5

`endif

/* pcpm_pkg.sv */
package pcpm_pkg;

   // Peripheral controls and output values
   typedef struct packed {
      logic osc_en;        // Low frequency oscillator on
      logic ccp1_out_en;   // Compare or PWM driving
      logic ccp1_out;      // Compare or PWM level
      logic ccp1_shut;     // Enhanced PWM shutdown
      logic ccp1_shut_tri; // Tri-state on shutdown
      logic ccp2_out_en;
      logic ccp2_out;
      logic ccp2_shut;
      logic ccp2_shut_tri;
      logic spi_en;        // Serial module in SPI mode
      logic i2c_en;        // Serial module in I2C mode
      logic spi_clk_out;
      logic spi_sdo;
      logic i2c_clk_low;   // Pull bus clock low
      logic i2c_dat_low;   // Pull bus data low
      logic i2c_smbus;     // Input threshold choice
   } pcpm_periph_t;

   // Input taps toward the peripherals
   typedef struct packed {
      logic timer_counter_input;
      logic ccp1_capture;
      logic ccp2_capture;
      logic spi_clock_pin;
      logic spi_data_in_pin;
      logic i2c_clock_pin;
      logic i2c_data_pin;
   } pcpm_taps_t;

   // Bus handshake state
   typedef enum logic [0:0] {
      PCPM_IDLE,
      PCPM_ACK
   } pcpm_bus_state_t;

endpackage : pcpm_pkg

/* pcpm_checker.sv */
`include "pcpm_regs.svh"

module pcpm_checker #(
   parameter int PINS = 8
) (
   input wire logic clock,
   input wire logic arst_n,
   input wire logic [3:0] address,
   input wire logic read,
   input wire logic write,
   input wire logic [3:0] byteenable,
   input wire logic [31:0] writedata,
   input wire logic [31:0] readdata,
   input wire logic waitrequest,
   input wire logic channel_two_pin_select,
   input wire pcpm_pkg::pcpm_periph_t periph,
   input wire pcpm_pkg::pcpm_taps_t taps,
   input wire logic ch2_alt_pin,
   input wire logic [PINS-1:0] pad_in,
   input wire logic [PINS-1:0] pad_out,
   input wire logic [PINS-1:0] pad_oe,
   input wire logic [1:0] pad_analog,
   input wire logic [1:0] pad_smbus
);
   default clocking @(posedge clock); endclocking
   default disable iff (!arst_n);

   logic wr_ok; // Write accepted at this edge
   logic [7:0] dir_sh; // Shadow of direction register
   logic [7:0] lat_sh; // Shadow of output latch
   logic [7:0] next_dir;
   logic [7:0] next_lat;

   assign wr_ok = write && !waitrequest && byteenable[0];

   // Shadow follows accepted writes only, so refused ones are ignored
   always_comb begin
      next_dir = dir_sh;
      next_lat = lat_sh;
      if (wr_ok && address == `PCPM_OFS_DIR) begin
         next_dir = writedata[7:0];
      end
      if (wr_ok && (address == `PCPM_OFS_LATCH ||
            address == `PCPM_OFS_PINS)) begin
         next_lat = writedata[7:0];
      end
   end

   // Shadow registers
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         dir_sh <= `PCPM_RST_DIR;
         lat_sh <= `PCPM_RST_LATCH;
      end else begin
         dir_sh <= next_dir;
         lat_sh <= next_lat;
      end
   end

   a_one_wait: assert property ((read || write) && waitrequest |=>
      !waitrequest) else $error("bus answer late");
   a_dir_tristate: assert property (
      pad_oe[7:6] == ~$past(dir_sh[7:6]))
      else $error("pad enable does not follow direction");
   a_latch_drive: assert property (pad_oe[7] |->
      pad_out[7] == $past(lat_sh[7])) else $error("pad not latch");
   a_dir_readback: assert property (read && !waitrequest &&
      address == `PCPM_OFS_DIR |-> readdata[7:0] == dir_sh)
      else $error("direction read wrong");
   a_osc_analog: assert property (
      periph.osc_en |-> pad_analog == 2'h3 ##1 pad_oe[1:0] == 2'h0)
      else $error("oscillator pins driven");
   a_ccp_override: assert property (
      periph.ccp1_out_en && !dir_sh[2] && !periph.ccp1_shut |=>
      pad_oe[2] && pad_out[2] == $past(periph.ccp1_out))
      else $error("compare output lost");
   // Shutdown only matters while the channel owns the pin
   a_pwm_shutdown: assert property (periph.ccp1_out_en &&
      periph.ccp1_shut && periph.ccp1_shut_tri |=> !pad_oe[2])
      else $error("shutdown drives");
   a_spi_clock: assert property (periph.spi_en && !dir_sh[3] |=>
      pad_oe[3] && pad_out[3] == $past(periph.spi_clk_out))
      else $error("spi clock lost");
   a_i2c_smbus: assert property (
      periph.i2c_en && !periph.spi_en |-> pad_smbus == {2{periph.i2c_smbus}})
      else $error("input type wrong");
   a_i2c_data: assert property (
      periph.i2c_en && !periph.spi_en |=>
      pad_oe[4] == $past(periph.i2c_dat_low) && !pad_out[4])
      else $error("i2c data drive wrong");
   a_spi_sdo: assert property (periph.spi_en && !dir_sh[5] |=>
      pad_oe[5] && pad_out[5] == $past(periph.spi_sdo))
      else $error("spi data out lost");

   c_spi: cover property (periph.spi_en && pad_oe[5]);
   c_i2c: cover property (periph.i2c_en && pad_oe[4]);
   c_dir_read: cover property (read && !waitrequest && address == 4'h8);
endmodule : pcpm_checker

bind port_c_pin_mux pcpm_checker #(.PINS(PINS)) u_chk (
   .clock(clock), .arst_n(arst_n), .address(address), .read(read),
   .write(write), .byteenable(byteenable), .writedata(writedata),
   .readdata(readdata), .waitrequest(waitrequest),
   .channel_two_pin_select(channel_two_pin_select), .periph(periph),
   .taps(taps), .ch2_alt_pin(ch2_alt_pin), .pad_in(pad_in),
   .pad_out(pad_out), .pad_oe(pad_oe), .pad_analog(pad_analog),
   .pad_smbus(pad_smbus));

/* pcpm_pad_env.sv */
module pcpm_pad_env (
   input wire logic [7:0] pad_out,
   input wire logic [7:0] pad_oe,
   input wire logic [7:0] ext,
   output logic [7:0] pad_in
);
   timeunit 1ns;
   timeprecision 1ns;
   // Board drives every pin the port leaves released
   assign pad_in = (pad_oe & pad_out) | (~pad_oe & ext);
endmodule : pcpm_pad_env

/* tb_port_c_pin_mux.sv */
`include "pcpm_regs.svh"
`define CHK(nm, e, g) begin checks++; if ((g) !== (e)) begin num_errors++; \
   $display("mismatch %s exp %h got %h", nm, e, g); end end

module tb_port_c_pin_mux;
   timeunit 1ns;
   timeprecision 1ns;
   logic clock = 1'b0;
   logic arst_n = 1'b0;
   logic read = 1'b0;
   logic write = 1'b0;
   logic channel_two_pin_select = 1'b1;
   logic [3:0] address = 4'h0;
   logic [3:0] byteenable = 4'hf;
   logic [31:0] writedata = 32'h0;
   logic [31:0] readdata;
   logic waitrequest;
   logic ch2_alt_pin;
   pcpm_pkg::pcpm_periph_t periph = '0;
   pcpm_pkg::pcpm_periph_t p;
   pcpm_pkg::pcpm_taps_t taps;
   logic [7:0] pad_in, pad_out, pad_oe;
   logic [7:0] ext = 8'h00; // Level the board puts on released pins
   logic [1:0] pad_analog, pad_smbus;
   logic [7:0] q, lat, dir;
   int num_errors = 0;
   int checks = 0;

   always #50 clock = ~clock;

   port_c_pin_mux #(.PINS(8)) DUT (.clock(clock), .arst_n(arst_n),
      .address(address), .read(read), .write(write),
      .byteenable(byteenable), .writedata(writedata), .readdata(readdata),
      .waitrequest(waitrequest),
      .channel_two_pin_select(channel_two_pin_select), .periph(periph),
      .taps(taps), .ch2_alt_pin(ch2_alt_pin), .pad_in(pad_in),
      .pad_out(pad_out), .pad_oe(pad_oe), .pad_analog(pad_analog),
      .pad_smbus(pad_smbus));

   pcpm_pad_env ENV (.pad_out(pad_out), .pad_oe(pad_oe), .ext(ext),
      .pad_in(pad_in));

   // Expected pin levels: latch where driven, board elsewhere
   function automatic logic [7:0] exp_pins(input logic [7:0] l, d, e);
      return (l & ~d) | (e & d);
   endfunction : exp_pins

   task automatic end_of_test;
      $display("checks %0d errors %0d", checks, num_errors);
      if (num_errors == 0 && checks > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask : end_of_test

   // One Avalon access, held until waitrequest is seen low
   task automatic bus(input logic wr, input logic [3:0] a,
         input logic [7:0] d, input logic [3:0] be, output logic [7:0] r);
      int n;
      n = 0;
      @(posedge clock);
      read <= !wr;
      write <= wr;
      address <= a;
      writedata <= {24'h0, d};
      byteenable <= be;
      do begin
         @(posedge clock);
         n++;
      end while (waitrequest !== 1'b0 && n < 20);
      r = readdata[7:0];
      read <= 1'b0;
      write <= 1'b0;
      if (n >= 20) begin
         num_errors++;
         end_of_test();
      end
   endtask : bus

   initial begin
      void'($urandom(32'hef22));
      repeat (12) @(posedge clock);
      arst_n <= 1'b1;
      bus(1'b0, `PCPM_OFS_DIR, 8'h00, 4'h1, q);
      `CHK("dir_reset", 8'hff, q)
      `CHK("oe_reset", 8'h00, pad_oe)
      bus(1'b0, `PCPM_OFS_STATUS, 8'h00, 4'h1, q);
      `CHK("pin_select", 1'b1, q[1])
      // Random latch, direction and board levels, with both direction extremes
      for (int i = 0; i < 8; i++) begin
         lat = 8'($urandom);
         dir = (i == 0) ? 8'h00 : (i == 1) ? 8'hff : 8'($urandom);
         ext <= 8'($urandom);
         bus(1'b1, i[0] ? `PCPM_OFS_PINS : `PCPM_OFS_LATCH, lat, 4'h1, q);
         bus(1'b1, `PCPM_OFS_DIR, dir, 4'h1, q);
         repeat (6) @(posedge clock);
         `CHK("pad_oe", ~dir, pad_oe)
         `CHK("pad_out", lat & ~dir, pad_out & pad_oe)
         bus(1'b0, `PCPM_OFS_LATCH, 8'h00, 4'h1, q);
         `CHK("latch", lat, q)
         bus(1'b0, `PCPM_OFS_PINS, 8'h00, 4'h1, q);
         `CHK("pins", exp_pins(lat, dir, ext), q)
      end
      // Refused accesses leave the latch alone
      bus(1'b1, `PCPM_OFS_LATCH, ~lat, 4'h0, q);
      bus(1'b1, `PCPM_OFS_STATUS, 8'hff, 4'h1, q);
      bus(1'b0, 4'h2, 8'h00, 4'h1, q);
      `CHK("unmapped", 8'h00, q)
      bus(1'b0, `PCPM_OFS_LATCH, 8'h00, 4'h1, q);
      `CHK("latch_kept", lat, q)
      // Peripheral outputs take over a cleared latch
      bus(1'b1, `PCPM_OFS_LATCH, 8'h00, 4'h1, q);
      bus(1'b1, `PCPM_OFS_DIR, 8'h00, 4'h1, q);
      p = '0;
      {p.spi_en, p.spi_sdo, p.spi_clk_out} = 3'h7;
      {p.ccp1_out_en, p.ccp1_out, p.ccp2_out_en, p.ccp2_out} = 4'hf;
      periph <= p;
      repeat (3) @(posedge clock);
      `CHK("override", 8'h2e, pad_out & pad_oe)
      bus(1'b0, `PCPM_OFS_DIR, 8'h00, 4'h1, q);
      `CHK("dir_kept", 8'h00, q)
      {p.ccp1_shut, p.ccp1_shut_tri} = 2'h3;
      periph <= p;
      repeat (3) @(posedge clock);
      `CHK("shutdown", 1'b0, pad_oe[2])
      // Input taps with every pin released
      p = '0;
      p.spi_en = 1'b1;
      periph <= p;
      ext <= 8'h1f;
      bus(1'b1, `PCPM_OFS_DIR, 8'hff, 4'h1, q);
      repeat (8) @(posedge clock);
      `CHK("ccp1_cap", 1'b1, taps.ccp1_capture)
      `CHK("ccp2_cap", 1'b1, taps.ccp2_capture)
      `CHK("spi_in", 1'b1, taps.spi_data_in_pin)
      `CHK("spi_clk_in", 1'b1, taps.spi_clock_pin)
      `CHK("counter_in", 1'b1, taps.timer_counter_input)
      p = '0;
      {p.i2c_en, p.i2c_dat_low, p.i2c_smbus} = 3'h7;
      periph <= p;
      repeat (8) @(posedge clock);
      // Open drain: enable high with a low level, wire read back low
      `CHK("i2c_data", 2'h2, {pad_oe[4], pad_out[4]})
      `CHK("i2c_dat_in", 1'b0, taps.i2c_data_pin)
      `CHK("smbus", 2'h3, pad_smbus)
      `CHK("i2c_clk_in", 1'b1, taps.i2c_clock_pin)
      bus(1'b0, `PCPM_OFS_STATUS, 8'h00, 4'h1, q);
      `CHK("status_i2c", 8'h0a, q)
      p = '0;
      p.osc_en = 1'b1;
      periph <= p;
      ext <= 8'hff;
      repeat (8) @(posedge clock);
      `CHK("analog", 2'h3, pad_analog)
      `CHK("osc_tap", 1'b0, taps.timer_counter_input)
      bus(1'b0, `PCPM_OFS_PINS, 8'h00, 4'h1, q);
      `CHK("osc_pins", 2'h0, q[1:0])
      // Second reset with channel two moved off this port
      periph <= '0;
      arst_n <= 1'b0;
      channel_two_pin_select <= 1'b0;
      repeat (3) @(posedge clock);
      arst_n <= 1'b1;
      repeat (3) @(posedge clock);
      `CHK("alt_pin", 1'b1, ch2_alt_pin)
      bus(1'b0, `PCPM_OFS_STATUS, 8'h00, 4'h1, q);
      `CHK("pin_select_off", 1'b0, q[1])
      // Pin 1 sits high, yet channel two must not capture it
      `CHK("ch2_cap_off", 1'b0, taps.ccp2_capture)
      end_of_test();
   end
endmodule : tb_port_c_pin_mux
